// ==== pkg/irq_event_defs.svh ====
// register offsets, field positions and reset values of the event/mask block
// assumes: included by bare name, definitions only
`ifndef IRQ_EVENT_DEFS_SVH
`define IRQ_EVENT_DEFS_SVH

`define OFS_EVENT_SET      8'h80
`define OFS_EVENT_CLEAR    8'h84
`define OFS_ENABLE_SET     8'h88
`define OFS_ENABLE_CLEAR   8'h8c
`define OFS_ISO_RX_EVENT   8'h90
`define OFS_ISO_RX_MASK    8'h94
`define OFS_ISO_TX_EVENT   8'h98
`define OFS_ISO_TX_MASK    8'h9c

`define BIT_REQ_SEND_DONE   0
`define BIT_RESP_SEND_DONE  1
`define BIT_ASYNC_RX_REQ    2
`define BIT_ISO_TX_SUM      6
`define BIT_ISO_RX_SUM      7
`define BIT_WRITE_FAULT     8
`define BIT_LOCK_UNACKED    9
`define BIT_MAKER_PRIVATE   30
`define BIT_GLOBAL_GATE     31

// bits that really hold event state; 15:10 and others read zero, except 7:6, which read the live iso summaries
`define EVENT_LATCH_MASK   32'h4000_0307
`define ENABLE_IMPL_MASK   32'hc000_03ff
`define EVENT_RESET        32'h0000_0000
`define ENABLE_RESET       32'h0000_0000
`define UNMAPPED_READ      32'h0000_0000

`endif

// ==== pkg/irq_event_pkg.sv ====
// types shared by the event/mask block
// assumes: nothing
package irq_event_pkg;

    typedef struct packed {
        logic       read;
        logic       write;
        logic [7:0] address;
        logic [31:0] writedata;
    } bus_req_t;

    typedef struct packed {
        logic req_send_done;
        logic resp_send_done;
        logic async_rx_req;
        logic write_fault;
        logic lock_unacked;
        logic maker_private;
    } event_pulses_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DONE = 2'b01
    } bus_state_t;

endpackage

// ==== rtl/ohci_interrupt_event_mask.sv ====
// host interrupt event flags, set/clear enable mask with global gate,
// and the isochronous receive/transmit summaries, behind an avalon-mm slave
// assumes: one clock, event pulses synchronous to core_clk, one cycle each
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
`include "irq_event_defs.svh"

module ohci_interrupt_event_mask #(
    parameter int ISO_CTX = 8
) (
    input  wire logic                        core_clk,
    input  wire logic                        srst,
    input  wire logic                        clk_en,
    input  wire logic [7:0]                  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic [31:0]                      avs_readdata,
    output logic                             avs_waitrequest,
    input  wire irq_event_pkg::event_pulses_t ev_pulse,
    input  wire logic [ISO_CTX-1:0]          iso_rx_ctx_pulse,
    input  wire logic [ISO_CTX-1:0]          iso_tx_ctx_pulse,
    output logic                             host_irq
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [31:0]        event_q,  event_d;
    logic [31:0]        enable_q, enable_d;
    logic [ISO_CTX-1:0] rx_ev_q, rx_ev_d, rx_mk_q, rx_mk_d;
    logic [ISO_CTX-1:0] tx_ev_q, tx_ev_d, tx_mk_q, tx_mk_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               irq_q, irq_d;
    logic               wait_q, wait_d;
    irq_event_pkg::bus_state_t st_q, st_d;
    logic [31:0]        bmask;
    logic [31:0]        wset, wclr;
    logic [31:0]        hw_set;
    logic [31:0]        event_view;
    logic               iso_rx_summary;
    logic               iso_tx_summary;
    logic               wr_go, rd_go;

    assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_go = avs_write && (st_q == irq_event_pkg::BUS_IDLE);
    assign rd_go = avs_read && (st_q == irq_event_pkg::BUS_IDLE);
    assign wset  = avs_writedata & bmask;
    assign wclr  = avs_writedata & bmask;

    // ------------------------------------------------------------------
    // summaries: live, never latched
    // ------------------------------------------------------------------
    assign iso_rx_summary = |(rx_ev_q & rx_mk_q);
    assign iso_tx_summary = |(tx_ev_q & tx_mk_q);

    always_comb begin
        hw_set = 32'h0000_0000;
        hw_set[`BIT_LOCK_UNACKED]    = ev_pulse.lock_unacked;
        hw_set[`BIT_WRITE_FAULT]     = ev_pulse.write_fault;
        hw_set[`BIT_ASYNC_RX_REQ]    = ev_pulse.async_rx_req;
        hw_set[`BIT_RESP_SEND_DONE]  = ev_pulse.resp_send_done;
        hw_set[`BIT_REQ_SEND_DONE]   = ev_pulse.req_send_done;
        hw_set[`BIT_MAKER_PRIVATE]   = ev_pulse.maker_private;
    end

    always_comb begin
        event_view = event_q & `EVENT_LATCH_MASK;
        event_view[`BIT_ISO_RX_SUM] = iso_rx_summary;
        event_view[`BIT_ISO_TX_SUM] = iso_tx_summary;
    end

    // ------------------------------------------------------------------
    // event flags: hardware set wins over a software clear
    // ------------------------------------------------------------------
    always_comb begin
        event_d = event_q;
        if (wr_go && (avs_address == `OFS_EVENT_SET)) begin
            event_d = event_q | wset;
        end
        if (wr_go && (avs_address == `OFS_EVENT_CLEAR)) begin
            event_d = event_q & ~wclr;
        end
        // set applied last so a pulse in the clear cycle is kept
        event_d = (event_d | hw_set) & `EVENT_LATCH_MASK;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            event_q <= `EVENT_RESET;
        end else if (clk_en) begin
            event_q <= event_d;
        end
    end

    // ------------------------------------------------------------------
    // enable mask: one register behind a set and a clear offset
    // ------------------------------------------------------------------
    always_comb begin
        enable_d = enable_q;
        if (wr_go && (avs_address == `OFS_ENABLE_SET)) begin
            enable_d = enable_q | wset;
        end
        if (wr_go && (avs_address == `OFS_ENABLE_CLEAR)) begin
            enable_d = enable_q & ~wclr;
        end
        // unbacked mask bits read zero instead of keeping stale writes
        enable_d = enable_d & `ENABLE_IMPL_MASK;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            enable_q <= `ENABLE_RESET;
        end else if (clk_en) begin
            enable_q <= enable_d;
        end
    end

    // ------------------------------------------------------------------
    // per-context isochronous events and masks
    // ------------------------------------------------------------------
    always_comb begin
        rx_ev_d = rx_ev_q;
        rx_mk_d = rx_mk_q;
        tx_ev_d = tx_ev_q;
        tx_mk_d = tx_mk_q;
        // masks are plain writes; events only clear from software
        if (wr_go) begin
            unique case (avs_address)
                `OFS_ISO_RX_EVENT: rx_ev_d = rx_ev_q & ~wclr[ISO_CTX-1:0];
                `OFS_ISO_RX_MASK:  rx_mk_d = wset[ISO_CTX-1:0];
                `OFS_ISO_TX_EVENT: tx_ev_d = tx_ev_q & ~wclr[ISO_CTX-1:0];
                `OFS_ISO_TX_MASK:  tx_mk_d = wset[ISO_CTX-1:0];
                default: ;
            endcase
        end
        // a context pulse in the clear cycle survives the clear
        rx_ev_d = rx_ev_d | iso_rx_ctx_pulse;
        tx_ev_d = tx_ev_d | iso_tx_ctx_pulse;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rx_ev_q <= '0;
            rx_mk_q <= '0;
            tx_ev_q <= '0;
            tx_mk_q <= '0;
        end else if (clk_en) begin
            rx_ev_q <= rx_ev_d;
            rx_mk_q <= rx_mk_d;
            tx_ev_q <= tx_ev_d;
            tx_mk_q <= tx_mk_d;
        end
    end

    // ------------------------------------------------------------------
    // interrupt: registered so the pin is glitch free, one cycle late
    // ------------------------------------------------------------------
    always_comb begin
        irq_d = enable_q[`BIT_GLOBAL_GATE] &&
                |(event_view[30:0] & enable_q[30:0]);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else if (clk_en) begin
            irq_q <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // bus slave: waitrequest high on entry, answer in the next cycle
    // ------------------------------------------------------------------
    always_comb begin
        st_d    = st_q;
        rdata_d = rdata_q;
        unique case (st_q)
            irq_event_pkg::BUS_IDLE: begin
                if (wr_go || rd_go) begin
                    st_d = irq_event_pkg::BUS_DONE;
                end
                if (rd_go) begin
                    unique case (avs_address)
                        `OFS_EVENT_SET,
                        `OFS_EVENT_CLEAR:  rdata_d = event_view;
                        `OFS_ENABLE_SET,
                        `OFS_ENABLE_CLEAR: rdata_d = enable_q;
                        `OFS_ISO_RX_EVENT: rdata_d = 32'(rx_ev_q);
                        `OFS_ISO_RX_MASK:  rdata_d = 32'(rx_mk_q);
                        `OFS_ISO_TX_EVENT: rdata_d = 32'(tx_ev_q);
                        `OFS_ISO_TX_MASK:  rdata_d = 32'(tx_mk_q);
                        default:           rdata_d = `UNMAPPED_READ;
                    endcase
                end
            end
            irq_event_pkg::BUS_DONE: st_d = irq_event_pkg::BUS_IDLE;
            default: st_d = irq_event_pkg::BUS_IDLE;
        endcase
        // own flop so the pin carries no decode glitch
        wait_d = (st_d != irq_event_pkg::BUS_DONE);
    end

    // readdata holds until the next read, so a slow master still sees it
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q    <= irq_event_pkg::BUS_IDLE;
            rdata_q <= 32'h0000_0000;
            wait_q  <= 1'b1;
        end else if (clk_en) begin
            st_q    <= st_d;
            rdata_q <= rdata_d;
            wait_q  <= wait_d;
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign host_irq        = irq_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_lock_sets_bit: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && ev_pulse.lock_unacked) |=> event_q[`BIT_LOCK_UNACKED])
        else $error("lock reply event not flagged");
    a_fault_sets_bit: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && ev_pulse.write_fault) |=> event_q[`BIT_WRITE_FAULT])
        else $error("write fault event not flagged");
    a_rx_summary_live: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && !wr_go && |(iso_rx_ctx_pulse & rx_mk_q)) |=> event_view[`BIT_ISO_RX_SUM])
        else $error("receive summary wrong");
    a_arq_sets_bit: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && ev_pulse.async_rx_req) |=> event_q[`BIT_ASYNC_RX_REQ])
        else $error("receive request event lost");
    a_resp_sets_bit: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && ev_pulse.resp_send_done) |=> event_q[`BIT_RESP_SEND_DONE])
        else $error("response done event lost");
    a_req_sets_bit: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && ev_pulse.req_send_done) |=> event_q[`BIT_REQ_SEND_DONE])
        else $error("request done event lost");
    a_reserved_zero: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && rd_go && (avs_address == `OFS_EVENT_SET || avs_address == `OFS_EVENT_CLEAR))
        |=> (avs_readdata[15:10] == 6'h00))
        else $error("reserved event bits nonzero");
    a_mask_readback: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && rd_go && (avs_address == `OFS_ENABLE_CLEAR)) |=> (avs_readdata == $past(enable_q)))
        else $error("mask readback wrong");
    a_gate_blocks: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && !enable_q[`BIT_GLOBAL_GATE]) |=> !host_irq)
        else $error("interrupt without global gate");
    a_irq_follows: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && enable_q[`BIT_GLOBAL_GATE] && |(event_view[30:0] & enable_q[30:0])) |=> host_irq)
        else $error("enabled event gave no interrupt");
    a_private_irq: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && &{enable_q[31:30], event_view[30]}) |=> host_irq)
        else $error("maker private event gave no interrupt");
    a_tx_summary_live: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && !wr_go && |(iso_tx_ctx_pulse & tx_mk_q)) |=> event_view[`BIT_ISO_TX_SUM])
        else $error("transmit summary wrong");
    a_clear_works: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && wr_go && avs_address == `OFS_ENABLE_CLEAR && wclr[0]) |=> !enable_q[0])
        else $error("mask clear did not clear");
    a_mask_set_works: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && wr_go && avs_address == `OFS_ENABLE_SET && wset[`BIT_GLOBAL_GATE]) |=> enable_q[`BIT_GLOBAL_GATE])
        else $error("mask set did not set");
    a_set_readback: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && rd_go && (avs_address == `OFS_ENABLE_SET)) |=> (avs_readdata == $past(enable_q)))
        else $error("mask readback at set offset wrong");
    a_set_beats_clear: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && wr_go && avs_address == `OFS_EVENT_CLEAR && ev_pulse.req_send_done)
        |=> event_q[`BIT_REQ_SEND_DONE])
        else $error("event lost to a clear in the same cycle");
    a_irq_drops: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && !(|(event_view[30:0] & enable_q[30:0]))) |=> !host_irq)
        else $error("interrupt without an enabled event");

    // ------------------------------------------------------------------
    // bus handshake and clock-enable checks
    // ------------------------------------------------------------------
    a_wait_one_cycle: assert property (@(posedge core_clk) disable iff (srst)
        (clk_en && !avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_freeze_holds: assert property (@(posedge core_clk) disable iff (srst)
        (!clk_en) |=> ($stable(event_q) && $stable(enable_q) && $stable(irq_q)))
        else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ==== tb/irq_line_sink.sv ====
// system interrupt line seen from the host side: counts assertions
// assumes: host_irq is a level synchronous to core_clk
`timescale 1ns/100ps
`default_nettype none
module irq_line_sink (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       host_irq,
    output logic [7:0]      rise_count
);
    logic line_q;
    always_ff @(posedge core_clk) begin
        line_q <= host_irq;
        if (srst) begin
            line_q     <= 1'b0;
            rise_count <= 8'h00;
        end else if (host_irq && !line_q) begin
            rise_count <= rise_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== tb/ohci_interrupt_event_mask_test.sv ====
// bench for the event/mask block: avalon reads and writes, event pulses
// assumes: design files and the package are compiled first
`timescale 1ns/100ps
`default_nettype none
module ohci_interrupt_event_mask_test;
    logic core_clk = 1'b0, srst = 1'b1, clk_en = 1'b1;
    logic [7:0] avs_address = 8'h00, rx_p = 8'h00, tx_p = 8'h00, rises;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, host_irq;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    irq_event_pkg::event_pulses_t ev_p = '0;
    int mismatches = 0, tests_run = 0, cycles = 0;
    int unsigned evbit [6] = '{0, 1, 2, 8, 9, 30};
    logic [31:0] acc;
    always #25 core_clk = ~core_clk;
    ohci_interrupt_event_mask #(.ISO_CTX(8)) dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ev_pulse(ev_p), .iso_rx_ctx_pulse(rx_p),
        .iso_tx_ctx_pulse(tx_p), .host_irq(host_irq));
    irq_line_sink sink (.core_clk(core_clk), .srst(srst), .host_irq(host_irq), .rise_count(rises));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge;
    // one idle edge after release so the next call never re-drives in the same step
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(q, exp);
    endtask
    // one-cycle pulses, then room for the interrupt line to settle
    task automatic pulse(input logic [5:0] e, input logic [7:0] r, input logic [7:0] t);
        ev_p <= irq_event_pkg::event_pulses_t'(e);
        rx_p <= r;
        tx_p <= t;
        @(posedge core_clk);
        ev_p <= '0;
        rx_p <= 8'h00;
        tx_p <= 8'h00;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rd(8'h88, 32'h0);
        bus(1'b1, 8'h88, 32'hffff_ffff);
        rd(8'h88, 32'hc000_03ff);
        rd(8'h8c, 32'hc000_03ff);
        bus(1'b1, 8'h8c, 32'h0000_0300);
        rd(8'h88, 32'hc000_00ff);
        bus(1'b1, 8'h88, 32'h0000_0300);
        acc = 32'h0;
        for (int k = 0; k < 6; k++) begin
            pulse(6'h20 >> k, 8'h00, 8'h00);
            acc = acc | (32'h1 << evbit[k]);
            rd(8'h80, acc);
        end
        check({31'h0, host_irq}, 32'h1);
        check({24'h0, rises}, 32'h1);
        rd(8'h84, acc);
        bus(1'b1, 8'h8c, 32'h8000_0000);
        repeat (3) @(posedge core_clk);
        check({31'h0, host_irq}, 32'h0);
        bus(1'b1, 8'h84, 32'hffff_ffff);
        bus(1'b1, 8'h80, 32'h0000_fc00);
        rd(8'h80, 32'h0);
        // only the maker-private enable left open
        bus(1'b1, 8'h8c, 32'h3fff_ffff);
        bus(1'b1, 8'h88, 32'h8000_0000);
        pulse(6'h20, 8'h00, 8'h00);
        check({31'h0, host_irq}, 32'h0);
        pulse(6'h01, 8'h00, 8'h00);
        check({31'h0, host_irq}, 32'h1);
        bus(1'b1, 8'h84, 32'hffff_ffff);
        // clear and hardware set in the same cycle: the set wins
        fork
            bus(1'b1, 8'h84, 32'h0000_0001);
            pulse(6'h20, 8'h00, 8'h00);
        join
        rd(8'h80, 32'h0000_0001);
        bus(1'b1, 8'h84, 32'hffff_ffff);
        // frozen clock enable: pulses must leave no trace
        clk_en <= 1'b0;
        pulse(6'h20, 8'h08, 8'h00);
        clk_en <= 1'b1;
        rd(8'h80, 32'h0);
        rd(8'h90, 32'h0);
        rd(8'h00, 32'h0);
        for (int j = 0; j < 2; j++) begin
            bus(1'b1, j ? 8'h9c : 8'h94, 32'h0000_0008);
            pulse(6'h00, j ? 8'h00 : 8'h20, j ? 8'h20 : 8'h00);
            rd(8'h80, 32'h0);
            pulse(6'h00, j ? 8'h00 : 8'h08, j ? 8'h08 : 8'h00);
            rd(8'h80, j ? 32'h40 : 32'h80);
            rd(j ? 8'h98 : 8'h90, 32'h0000_0028);
            rd(j ? 8'h9c : 8'h94, 32'h0000_0008);
            bus(1'b1, j ? 8'h98 : 8'h90, 32'h0000_0028);
            rd(8'h80, 32'h0);
        end
        close_out();
    end
endmodule
`default_nettype wire
